/* hdl/pcsd_pkg.sv */
/*
  Constants, types and register map of the peripheral clock source
  selectors and dividers. Assumes a single 125 MHz bus clock.
*/
package pcsd_pkg;

  // ****************************************************************
  // Sizes and register map
  // ****************************************************************
  localparam int NCH = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // Channel order: timer three, timer four, watchdog, flexible I/O,
  // I2C zero, I2C one, SPI zero, SPI one
  localparam int CH_WDT = 2;
  localparam logic [ADDR_W-1:0] SEL_ADDR [NCH] = '{
    8'hC0, 8'hC8, 8'h00, 8'hD8, 8'hE0, 8'hE8, 8'hF0, 8'hF8};
  localparam logic [ADDR_W-1:0] DIV_ADDR [NCH] = '{
    8'hC4, 8'hCC, 8'hD4, 8'hDC, 8'hE4, 8'hEC, 8'hF4, 8'hFC};
  // Watchdog has a divider only
  localparam logic [NCH-1:0] HAS_SEL = 8'hFB;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int SEL_W = 3;
  localparam int DIV_W = 4;
  localparam int RST_BIT = 29;
  localparam int HALT_BIT = 30;
  localparam int UNSET_BIT = 31;
  localparam logic [SEL_W-1:0] SEL_RESET = 3'h7;
  localparam logic [DIV_W-1:0] DIV_RESET = 4'h0;

  // Source codes; the code is also the index of the root clock input
  typedef enum logic [SEL_W-1:0] {
    CODE_LF_DIV = 3'b000,
    CODE_HF_GATED = 3'b001,
    CODE_HF_DIV = 3'b010,
    CODE_EXT = 3'b011,
    CODE_16K = 3'b100,
    CODE_1M = 3'b101,
    CODE_PLL = 3'b110,
    CODE_NONE = 3'b111
  } pcsd_code_e;
  localparam int NROOT = 7;

  // Legal codes per selector kind, bit n set when code n routes a clock
  localparam logic [7:0] MASK_TIMER = 8'h7B;
  localparam logic [7:0] MASK_FLEX = 8'h6B;
  localparam logic [7:0] MASK_SERIAL = 8'h6D;
  localparam logic [7:0] CH_MASK [NCH] = '{
    MASK_TIMER, MASK_TIMER, 8'h00, MASK_FLEX,
    MASK_SERIAL, MASK_SERIAL, MASK_SERIAL, MASK_SERIAL};

  // ****************************************************************
  // Divider control and bus answers
  // ****************************************************************
  typedef struct packed {
    logic halt;
    logic rst;
    logic [DIV_W-1:0] div;
  } pcsd_div_s;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pcsd_pkg

/* hdl/pcsd_top.sv */
/*
  Peripheral clock source selectors and integer dividers behind an
  AXI4-Lite slave. Root clocks arrive as levels synchronous to MCLK and
  slower than MCLK/2; divided clocks leave as registered levels.
*/
// Notes on behaviour
// - Selector register holds a 3-bit source code in bits 2-0; upper bits reserved.
// - Timer codes: 000 LF divided, 001 HF gated, 011 ext, 100 16k, 101 1M, 110 PLL.
// - Flexible I/O codes as timers but without the sixteen kHz source.
// - I2C and SPI codes: 010 HF divided, plus LF, ext, 1M and PLL.
// - Code 111 and any unlisted code route no clock.
// - Divider divides the selected source by its 4-bit field plus one.
// - Bit 31 of the divider register reads one while the output is unsettled.
// - Bit 30 halts the divider counter and stops the divided clock.
// - Bit 29 holds the divider counter in reset.
`timescale 1ns/1ps
module pcsd_top
  import pcsd_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Root clocks, indexed by source code
  input wire logic [pcsd_pkg::NROOT-1:0] ROOT_CLK,
  input wire logic WDT_SRC_CLK,
  // Divided functional clocks
  output logic [pcsd_pkg::NCH-1:0] FUNC_CLK,
  // AXI4-Lite write address
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [pcsd_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  // AXI4-Lite write data
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [pcsd_pkg::DATA_W-1:0] S_AXI_WDATA,
  input wire logic [pcsd_pkg::STRB_W-1:0] S_AXI_WSTRB,
  // AXI4-Lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // AXI4-Lite read address
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [pcsd_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  // AXI4-Lite read data
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [pcsd_pkg::DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP
);
  import pcsd_pkg::*;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  typedef struct packed {
    logic hit;
    logic is_div;
    logic [2:0] ch;
  } pcsd_dec_s;

  function automatic pcsd_dec_s pcsd_decode(input logic [ADDR_W-1:0] addr);
    pcsd_dec_s d;
    d = '0;
    for (int i = 0; i < NCH; i++) begin
      if (HAS_SEL[i] && addr == SEL_ADDR[i]) begin
        d.hit = 1'b1;
        d.ch = 3'(i);
      end
      if (addr == DIV_ADDR[i]) begin
        d.hit = 1'b1;
        d.is_div = 1'b1;
        d.ch = 3'(i);
      end
    end
    return d;
  endfunction : pcsd_decode

  // ****************************************************************
  // Register file and AXI4-Lite slave
  // ****************************************************************
  logic [SEL_W-1:0] sel_ff [NCH];
  logic [SEL_W-1:0] nxt_sel [NCH];
  pcsd_div_s dctl_ff [NCH];
  pcsd_div_s nxt_dctl [NCH];
  logic [NCH-1:0] div_chg;
  logic [NCH-1:0] unset_ff;
  logic aw_full_ff, nxt_aw_full;
  logic w_full_ff, nxt_w_full;
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic [DATA_W-1:0] wdata_ff, nxt_wdata;
  logic [STRB_W-1:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;

  assign S_AXI_AWREADY = ~aw_full_ff;
  assign S_AXI_WREADY = ~w_full_ff;
  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP = bresp_ff;
  assign S_AXI_ARREADY = ~rvalid_ff;
  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RDATA = rdata_ff;
  assign S_AXI_RRESP = rresp_ff;

  always_comb begin
    pcsd_dec_s wd;
    pcsd_dec_s rd;
    logic [DATA_W-1:0] cur;
    logic [DATA_W-1:0] mask;
    logic [DATA_W-1:0] val;
    wd = pcsd_decode(awaddr_ff);
    rd = pcsd_decode(S_AXI_ARADDR);
    cur = '0;
    mask = '0;
    val = '0;
    nxt_sel = sel_ff;
    nxt_dctl = dctl_ff;
    div_chg = '0;
    nxt_aw_full = aw_full_ff;
    nxt_w_full = w_full_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    // Address and data are taken independently, in either order
    if (S_AXI_AWVALID && !aw_full_ff) begin
      nxt_aw_full = 1'b1;
      nxt_awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_full_ff) begin
      nxt_w_full = 1'b1;
      nxt_wdata = S_AXI_WDATA;
      nxt_wstrb = S_AXI_WSTRB;
    end
    if (bvalid_ff && S_AXI_BREADY) begin
      nxt_bvalid = 1'b0;
    end
    // Commit only once the previous response has gone
    if (aw_full_ff && w_full_ff && !bvalid_ff) begin
      nxt_aw_full = 1'b0;
      nxt_w_full = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = wd.hit ? RESP_OKAY : RESP_SLVERR;
      for (int b = 0; b < STRB_W; b++) begin
        mask[b*8 +: 8] = {8{wstrb_ff[b]}};
      end
      if (wd.is_div) begin
        cur[DIV_W-1:0] = dctl_ff[wd.ch].div;
        cur[RST_BIT] = dctl_ff[wd.ch].rst;
        cur[HALT_BIT] = dctl_ff[wd.ch].halt;
      end else begin
        cur[SEL_W-1:0] = sel_ff[wd.ch];
      end
      val = (cur & ~mask) | (wdata_ff & mask);
      if (wd.hit && wd.is_div) begin
        nxt_dctl[wd.ch].div = val[DIV_W-1:0];
        nxt_dctl[wd.ch].halt = val[HALT_BIT];
        nxt_dctl[wd.ch].rst = val[RST_BIT];
        div_chg[wd.ch] = (val[DIV_W-1:0] != dctl_ff[wd.ch].div);
      end else if (wd.hit) begin
        nxt_sel[wd.ch] = val[SEL_W-1:0];
      end
    end
    if (rvalid_ff && S_AXI_RREADY) begin
      nxt_rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && !rvalid_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = rd.hit ? RESP_OKAY : RESP_SLVERR;
      nxt_rdata = '0;
      if (rd.hit && rd.is_div) begin
        nxt_rdata[DIV_W-1:0] = dctl_ff[rd.ch].div;
        nxt_rdata[RST_BIT] = dctl_ff[rd.ch].rst;
        nxt_rdata[HALT_BIT] = dctl_ff[rd.ch].halt;
        nxt_rdata[UNSET_BIT] = unset_ff[rd.ch];
      end else if (rd.hit) begin
        nxt_rdata[SEL_W-1:0] = sel_ff[rd.ch];
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      for (int i = 0; i < NCH; i++) begin
        sel_ff[i] <= SEL_RESET;
        dctl_ff[i] <= '{halt: 1'b0, rst: 1'b0, div: DIV_RESET};
      end
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else begin
      sel_ff <= nxt_sel;
      dctl_ff <= nxt_dctl;
      aw_full_ff <= nxt_aw_full;
      w_full_ff <= nxt_w_full;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // ****************************************************************
  // Source selection and division, one per channel
  // ****************************************************************
  // Changing source while the peripheral clock is live may glitch;
  // software is expected to gate the peripheral first.
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic src;
    logic src_d_ff, nxt_src_d;
    logic [DIV_W-1:0] cnt_ff, nxt_cnt;
    logic out_ff, nxt_out;
    logic nxt_unset;

    always_comb begin
      logic rise;
      logic wrap;
      logic [DIV_W:0] half;
      rise = 1'b0;
      wrap = 1'b0;
      half = '0;
      if (g == CH_WDT) begin
        src = WDT_SRC_CLK;
      end else begin
        src = CH_MASK[g][sel_ff[g]] && (sel_ff[g] != CODE_NONE) &&
              ROOT_CLK[sel_ff[g][SEL_W-1:0]];
      end
      nxt_src_d = src;
      nxt_cnt = cnt_ff;
      nxt_out = out_ff;
      rise = src & ~src_d_ff;
      wrap = (cnt_ff == dctl_ff[g].div);
      half = ({1'b0, dctl_ff[g].div} + 5'h1) >> 1;
      if (dctl_ff[g].rst) begin
        nxt_cnt = '0;
        nxt_out = 1'b0;
      end else if (dctl_ff[g].halt) begin
        nxt_out = 1'b0;
      end else if (dctl_ff[g].div == '0) begin
        nxt_cnt = '0;
        nxt_out = src;
      end else if (rise) begin
        // period of div plus one source cycles
        nxt_cnt = wrap ? '0 : DIV_W'(cnt_ff + 4'h1);
        nxt_out = ({1'b0, nxt_cnt} < half);
      end
      // set on change wins over settle
      nxt_unset = div_chg[g] | dctl_ff[g].rst |
                  (unset_ff[g] & ~(rise & wrap & ~dctl_ff[g].halt));
    end

    always_ff @(posedge MCLK) begin
      if (RST) begin
        src_d_ff <= 1'b0;
        cnt_ff <= '0;
        out_ff <= 1'b0;
        unset_ff[g] <= 1'b0;
      end else begin
        src_d_ff <= nxt_src_d;
        cnt_ff <= nxt_cnt;
        out_ff <= nxt_out;
        unset_ff[g] <= nxt_unset;
      end
    end

    assign FUNC_CLK[g] = out_ff;
  end

endmodule : pcsd_top

/* tb/pcsd_props.sv */
/*
  Bus and clock output checks for pcsd_top.
  Assumes it is bound to pcsd_top, with pcsd_pkg compiled first.
*/
`timescale 1ns/1ps
module pcsd_props
  import pcsd_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Divided clocks
  input wire logic [pcsd_pkg::NCH-1:0] FUNC_CLK,
  // Write side
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  // Read side
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [pcsd_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [pcsd_pkg::DATA_W-1:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // ****************
  // Assertions
  // ****************
  write_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
    && S_AXI_WREADY && !S_AXI_BVALID |-> ##[1:2] S_AXI_BVALID)
    else $error("write answer late");
  read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  write_release_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write answer stuck");
  read_release_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read answer stuck");
  read_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while answer pending");
  bad_read_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 8'hD0
    |=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == '0)
    else $error("unmapped read answered");
  sel_reserved_a: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 8'hC0
    |=> S_AXI_RRESP == RESP_OKAY && S_AXI_RDATA[31:3] == '0)
    else $error("selector upper bits not zero");
  reset_quiet_a: assert property (
    $fell(RST) |-> !S_AXI_BVALID && !S_AXI_RVALID && FUNC_CLK == '0)
    else $error("outputs active after reset");
  cover property (S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR);
  cover property ($rose(FUNC_CLK[2]));
  cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule : pcsd_props

bind pcsd_top pcsd_props u_props (.MCLK(MCLK), .RST(RST), .FUNC_CLK(FUNC_CLK),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP));

/* tb/pcsd_root_model.sv */
/*
  Root clock sources: bit n toggles every n+2 cycles, watchdog every 9.
  Assumes MCLK and RST of the bench; levels change after rising edges.
*/
`timescale 1ns/1ps
module pcsd_root_model (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Root levels
  output logic [6:0] ROOT_CLK,
  output logic WDT_SRC_CLK
);
  logic [3:0] cnt_ff [8];
  logic [7:0] lvl_ff;
  // Distinct rates so a wrong code mapping shows as a wrong period
  always_ff @(posedge MCLK) begin
    for (int n = 0; n < 8; n++) begin
      if (RST || cnt_ff[n] == 4'(n + 1)) begin
        cnt_ff[n] <= 4'h0;
        lvl_ff[n] <= RST ? 1'b0 : ~lvl_ff[n];
      end else begin
        cnt_ff[n] <= cnt_ff[n] + 4'h1;
      end
    end
  end
  assign ROOT_CLK = lvl_ff[6:0];
  assign WDT_SRC_CLK = lvl_ff[7];
endmodule : pcsd_root_model

/* tb/tb.sv */
/*
  Self-checking bench for pcsd_top: registers, source codes and dividers.
  Assumes pcsd_root_model drives the root clocks.
*/
`timescale 1ns/1ps
module tb;
  import pcsd_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic [1:0] r;
  } pcsd_row_s;
  localparam pcsd_row_s ROWS [6] = '{'{8'hC0, 32'hFFFFFFFF, 32'h7, 2'h0},
    '{8'hC4, 32'hFFFFFFFF, 32'hE000000F, 2'h0}, '{8'hD0, 32'h12345678, 32'h0, 2'h2},
    '{8'hDC, 32'h40000003, 32'hC0000003, 2'h0}, '{8'hE8, 32'hFFFFFFFA, 32'h2, 2'h0},
    '{8'hFC, 32'h0, 32'h0, 2'h0}};
  localparam int CHN [3] = '{0, 3, 4};
  localparam logic [7:0] SELA [3] = '{8'hC0, 8'hD8, 8'hE0};
  localparam logic [7:0] DIVA [3] = '{8'hC4, 8'hDC, 8'hE4};
  localparam logic [7:0] MSK [3] = '{8'h7B, 8'h6B, 8'h6D};
  localparam int DIVS [4] = '{0, 1, 2, 5};
  // Selector channels the code sweep leaves out, each given one legal code
  localparam int XCH [4] = '{1, 5, 6, 7};
  localparam logic [7:0] XSEL [4] = '{8'hC8, 8'hE8, 8'hF0, 8'hF8};
  localparam int XCODE [4] = '{4, 5, 6, 3};
  logic MCLK, RST, aw_valid, w_valid, b_ready, ar_valid, r_ready, wdt_clk;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
  logic [7:0] aw_addr, ar_addr, func_clk;
  logic [31:0] w_data, r_data, q;
  logic [1:0] b_resp, r_resp, r;
  logic [6:0] root_clk;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int p;

  pcsd_root_model u_root (.MCLK(MCLK), .RST(RST), .ROOT_CLK(root_clk),
    .WDT_SRC_CLK(wdt_clk));
  pcsd_top dut (.MCLK(MCLK), .RST(RST), .ROOT_CLK(root_clk), .WDT_SRC_CLK(wdt_clk),
    .FUNC_CLK(func_clk), .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready),
    .S_AXI_AWADDR(aw_addr), .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(w_valid),
    .S_AXI_WREADY(w_ready), .S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hF),
    .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready), .S_AXI_BRESP(b_resp),
    .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready), .S_AXI_ARADDR(ar_addr),
    .S_AXI_ARPROT(3'h0), .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready),
    .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp));

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Handshakes are judged at the falling edge, mid-cycle, where they are settled
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic [1:0] rr);
    logic pa, pw, xa, xw, hb;
    pa = 1'b1;
    pw = wr;
    hb = 1'b0;
    @(posedge MCLK);
    aw_valid <= wr;
    w_valid <= wr;
    ar_valid <= !wr;
    aw_addr <= a;
    ar_addr <= a;
    w_data <= d;
    b_ready <= wr;
    r_ready <= !wr;
    while (!hb) begin
      @(negedge MCLK);
      xa = pa && (wr ? aw_ready : ar_ready);
      xw = pw && w_ready;
      hb = wr ? b_valid === 1'b1 : r_valid === 1'b1;
      rq = r_data;
      rr = wr ? b_resp : r_resp;
      @(posedge MCLK);
      if (xa) begin
        pa = 1'b0;
        aw_valid <= 1'b0;
        ar_valid <= 1'b0;
      end
      if (xw) begin
        pw = 1'b0;
        w_valid <= 1'b0;
      end
    end
    b_ready <= 1'b0;
    r_ready <= 1'b0;
  endtask : bus

  // Cycles between two rising edges; 0 if none, -1 if stuck high
  task automatic period(input int ch, output int pr);
    int n, e0;
    logic pv;
    n = 0;
    e0 = -1;
    pr = 0;
    pv = 1'b1;
    repeat (40) @(posedge MCLK);
    repeat (300) begin
      @(negedge MCLK);
      if (func_clk[ch] === 1'b1 && pv === 1'b0 && pr == 0) begin
        if (e0 < 0) e0 = n;
        else pr = n - e0;
      end
      pv = func_clk[ch];
      n++;
    end
    if (pr == 0 && pv !== 1'b0) pr = -1;
  endtask : period

  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end

  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    {RST, aw_valid, w_valid, b_ready, ar_valid, r_ready} = 6'h20;
    {aw_addr, ar_addr, w_data} = '0;
    repeat (20) @(posedge MCLK);
    RST <= 1'b0;
    bus(0, 8'hD8, 32'h0, q, r);
    chk(q, 32'h7);
    bus(0, 8'hC4, 32'h0, q, r);
    chk(q, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      bus(1, ROWS[i].a, ROWS[i].d, q, r);
      chk(32'(r), 32'(ROWS[i].r));
      bus(0, ROWS[i].a, 32'h0, q, r);
      chk(q, ROWS[i].q);
      chk(32'(r), 32'(ROWS[i].r));
    end
    $display("test register rows done");
    for (int c = 0; c < 3; c++) begin
      bus(1, DIVA[c], 32'h0, q, r);
      for (int k = 0; k < 8; k++) begin
        bus(1, SELA[c], 32'(k), q, r);
        period(CHN[c], p);
        chk(32'(p), 32'(MSK[c][k] ? 2 * (k + 2) : 0));
      end
    end
    $display("test source codes done");
    for (int c = 0; c < 4; c++) begin
      bus(1, XSEL[c], 32'(XCODE[c]), q, r);
      period(XCH[c], p);
      chk(32'(p), 32'(2 * (XCODE[c] + 2)));
    end
    $display("test other channels done");
    bus(1, 8'hE0, 32'h2, q, r);
    for (int i = 0; i < 4; i++) begin
      bus(1, 8'hE4, 32'(DIVS[i]), q, r);
      period(4, p);
      chk(32'(p), 32'(8 * (DIVS[i] + 1)));
    end
    bus(1, 8'hD4, 32'h1, q, r);
    period(2, p);
    chk(32'(p), 32'h24);
    $display("test ratios done");
    bus(1, 8'hE4, 32'h40000000, q, r);
    period(4, p);
    chk(32'(p), 32'h0);
    bus(1, 8'hE4, 32'h20000000, q, r);
    period(4, p);
    chk(32'(p), 32'h0);
    bus(0, 8'hE4, 32'h0, q, r);
    chk(q, 32'hA0000000);
    bus(1, 8'hE4, 32'h0, q, r);
    period(4, p);
    chk(32'(p), 32'h8);
    bus(0, 8'hE4, 32'h0, q, r);
    chk(q, 32'h0);
    $display("test halt and counter reset done");
    RST <= 1'b1;
    repeat (3) @(posedge MCLK);
    chk(32'(func_clk), 32'h0);
    RST <= 1'b0;
    bus(0, 8'hE0, 32'h0, q, r);
    chk(q, 32'h7);
    $display("test second reset done");
    summarize();
  end
endmodule : tb
